// ---- core/obd_pkg.sv ----
/*
  Shared constants and types of the option byte decoder: register offsets,
  option byte indices, field positions, decode codes and reset values.
  Assumes a 32-bit AHB-Lite bus whose slave select covers this block only.
*/
`default_nettype none

package obd_pkg;

  // ********************************************************************
  // Option storage
  // ********************************************************************
  localparam int OPT_COUNT = 9;
  localparam int OPT_IDX_W = 4;
  localparam logic [3:0] IDX_CLK_WDG = 4'h0;
  localparam logic [3:0] IDX_EXT_WAKE = 4'h1;
  localparam logic [3:0] IDX_SETTLE = 4'h2;
  localparam logic [3:0] IDX_UNPROT = 4'h3;
  localparam logic [3:0] IDX_RSVD = 4'h4;
  localparam logic [3:0] IDX_KEY0 = 4'h5;
  localparam logic [3:0] IDX_KEY3 = 4'h8;

  // ********************************************************************
  // Register byte offsets
  // ********************************************************************
  localparam logic [7:0] OFS_CLK_WDG = 8'h00;
  localparam logic [7:0] OFS_KEY3 = 8'h20;
  localparam logic [7:0] OFS_CTRL = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int BIT_TRIM_WIDE = 0;
  localparam int BIT_SLOW_ALLOW = 1;
  localparam int BIT_INDEP_HW = 2;
  localparam int BIT_WINDOW_HW = 3;
  localparam int BIT_HALT_RST = 4;
  localparam int BIT_DIV_LO = 0;
  localparam int BIT_WAKE_SRC = 2;
  localparam int BIT_EXT_CLK = 3;
  localparam int CTRL_TRIM_LO = 0;
  localparam int CTRL_SLOW_SEL = 4;
  localparam int CTRL_INDEP_START = 5;
  localparam int CTRL_WINDOW_START = 6;
  localparam int CTRL_UNLOCK = 7;
  localparam int STAT_LOADED = 0;
  localparam int STAT_KEY_VALID = 1;
  localparam int STAT_UNPROT_EN = 2;
  localparam int STAT_DIV_VALID = 3;
  localparam int STAT_TRIM_WIDE = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ********************************************************************
  // Decode codes
  // ********************************************************************
  localparam logic [7:0] SETTLE_CODE_HALF = 8'hE1;
  localparam logic [7:0] SETTLE_CODE_8 = 8'hD2;
  localparam logic [7:0] SETTLE_CODE_128 = 8'hB4;
  localparam logic [7:0] SETTLE_CODE_2048 = 8'h00;
  // Counts are in half oscillator cycles so that 0.5 cycles stays exact
  localparam logic [12:0] SETTLE_HALF_1 = 13'h0001;
  localparam logic [12:0] SETTLE_HALF_16 = 13'h0010;
  localparam logic [12:0] SETTLE_HALF_256 = 13'h0100;
  localparam logic [12:0] SETTLE_HALF_4096 = 13'h1000;
  localparam logic [3:0] UNPROT_OFF_CODE = 4'h5;
  localparam logic [7:0] KEY_BAD_LOW = 8'h00;
  localparam logic [7:0] KEY_BAD_HIGH = 8'hFF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0]
  {
    OBD_DIV_RSVD = 2'h0,
    OBD_DIV_16M = 2'h1,
    OBD_DIV_8M = 2'h2,
    OBD_DIV_4M = 2'h3
  } obd_div_t;

  typedef enum {OBD_LD_FETCH, OBD_LD_CAPTURE, OBD_LD_APPLY, OBD_LD_DONE} obd_ld_t;

endpackage : obd_pkg

`default_nettype wire

// ---- core/obd_mem_if.sv ----
/*
  Connection between the decoder and its option storage: one write port
  and two read ports (loader and bus).
  Assumes both ends run on the same clock.
*/
`default_nettype none

interface obd_mem_if;
  logic wr_en;
  logic [obd_pkg::OPT_IDX_W-1:0] wr_idx;
  logic [7:0] wr_data;
  logic [obd_pkg::OPT_IDX_W-1:0] rd_idx [2];
  logic [7:0] rd_data [2];

  modport mem
  (
    input wr_en,
    input wr_idx,
    input wr_data,
    input rd_idx,
    output rd_data
  );

  modport user
  (
    output wr_en,
    output wr_idx,
    output wr_data,
    output rd_idx,
    input rd_data
  );
endinterface : obd_mem_if

`default_nettype wire

// ---- core/obd_opt_mem.sv ----
/*
  Option byte storage: a small array with no reset, so its contents
  survive the system reset like non-volatile cells.
  Assumes indices below DEPTH; read data are registered, one cycle late.
*/
`default_nettype none

module obd_opt_mem #(
  parameter int DEPTH = obd_pkg::OPT_COUNT
) (
  input wire logic clk,
  obd_mem_if.mem port
);

  logic [7:0] cell_q [DEPTH];

  if (DEPTH < 1 || DEPTH > (1 << obd_pkg::OPT_IDX_W))
  begin : g_bad_depth
    $error("obd_opt_mem: DEPTH out of range");
  end

  always_ff @(posedge clk)
  begin
    if (port.wr_en)
    begin
      cell_q[port.wr_idx] <= port.wr_data;
    end
  end

  // Same-cycle write is forwarded so a read right after a write sees it
  for (genvar p = 0; p < 2; p++)
  begin : g_rd
    always_ff @(posedge clk)
    begin
      if (port.wr_en && port.wr_idx == port.rd_idx[p])
      begin
        port.rd_data[p] <= port.wr_data;
      end
      else
      begin
        port.rd_data[p] <= cell_q[port.rd_idx[p]];
      end
    end
  end

endmodule : obd_opt_mem

`default_nettype wire

// ---- core/obd_top.sv ----
/*
  Option byte decoder: holds the option bytes, loads them once after reset
  and drives the decoded configuration to the rest of the chip; software
  reaches the bytes and a control/status pair over AHB-Lite.
  Assumes HALT_ENTRY and WINDOW_DOG_ACTIVE come from logic on CLK.
*/
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`default_nettype none

module obd_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  input wire logic HALT_ENTRY,
  input wire logic WINDOW_DOG_ACTIVE,
  output logic OPTIONS_LOADED,
  output logic FAST_OSC_TRIM_WIDTH,
  output logic [3:0] FAST_OSC_TRIM,
  output logic SLOW_OSC_CPU_ALLOW,
  output logic SLOW_OSC_CPU_SEL,
  output logic INDEP_DOG_AUTO_START,
  output logic INDEP_DOG_RUN,
  output logic WINDOW_DOG_AUTO_START,
  output logic WINDOW_DOG_RUN,
  output logic WINDOW_DOG_HALT_RESET,
  output logic HALT_RESET_REQ,
  output logic EXT_CLOCK_SELECT,
  output logic WAKEUP_CLOCK_SOURCE,
  output logic [1:0] WAKEUP_CLOCK_DIVIDER,
  output logic WAKEUP_DIVIDER_VALID,
  output logic [12:0] CRYSTAL_SETTLE_HALF,
  output logic TEMP_UNPROTECT_EN,
  output logic [31:0] TEMP_UNPROTECT_KEY,
  output logic TEMP_KEY_VALID
);

  // ********************************************************************
  // Decoding helpers
  // ********************************************************************
  // Only the low address byte is decoded; HSEL qualifies the region
  function automatic logic opt_hit(input logic [7:0] addr);
    opt_hit = addr[1:0] == 2'h0 && addr >= obd_pkg::OFS_CLK_WDG && addr <= obd_pkg::OFS_KEY3;
  endfunction : opt_hit

  function automatic logic [3:0] opt_index(input logic [7:0] addr);
    opt_index = addr[5:2];
  endfunction : opt_index

  function automatic logic [12:0] settle_count(input logic [7:0] code);
    case (code)
      obd_pkg::SETTLE_CODE_HALF: settle_count = obd_pkg::SETTLE_HALF_1;
      obd_pkg::SETTLE_CODE_8: settle_count = obd_pkg::SETTLE_HALF_16;
      obd_pkg::SETTLE_CODE_128: settle_count = obd_pkg::SETTLE_HALF_256;
      // Unlisted codes take the longest wait: a too-early crystal is worse
      default: settle_count = obd_pkg::SETTLE_HALF_4096;
    endcase
  endfunction : settle_count

  function automatic logic key_ok(input logic [7:0] key);
    key_ok = key != obd_pkg::KEY_BAD_LOW && key != obd_pkg::KEY_BAD_HIGH;
  endfunction : key_ok

  // ********************************************************************
  // Storage
  // ********************************************************************
  obd_mem_if mem_bus ();

  obd_opt_mem #(
    .DEPTH(obd_pkg::OPT_COUNT)
  ) u_opt_mem (
    .clk(CLK),
    .port(mem_bus.mem)
  );

  // ********************************************************************
  // AHB-Lite slave
  // ********************************************************************
  logic accept;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic hready_q;
  logic [31:0] hrdata_q;
  logic [7:0] ctrl_q;
  logic [7:0] status;
  logic opt_write;

  assign accept = HSEL && HREADY && HTRANS[1];

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= accept && HWRITE;
      rd_pend_q <= accept && !HWRITE;
      if (accept)
      begin
        addr_q <= HADDR[7:0];
      end
    end
  end

  // Reads take one wait state since option data leave the array registered
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      hready_q <= 1'b1;
      HRESP <= obd_pkg::HRESP_OKAY;
    end
    else
    begin
      hready_q <= !(accept && !HWRITE);
      HRESP <= obd_pkg::HRESP_OKAY;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      hrdata_q <= 32'h0000_0000;
    end
    else if (rd_pend_q)
    begin
      if (opt_hit(addr_q) && opt_index(addr_q) != obd_pkg::IDX_RSVD)
      begin
        hrdata_q <= {24'h00_0000, mem_bus.rd_data[1]};
      end
      else if (addr_q == obd_pkg::OFS_CTRL)
      begin
        hrdata_q <= {24'h00_0000, ctrl_q};
      end
      else if (addr_q == obd_pkg::OFS_STATUS)
      begin
        hrdata_q <= {24'h00_0000, status};
      end
      else
      begin
        hrdata_q <= 32'h0000_0000;
      end
    end
  end

  assign HREADYOUT = hready_q;
  assign HRDATA = hrdata_q;

  // Option bytes change only while unlocked; the reserved byte never does
  assign opt_write = wr_pend_q && opt_hit(addr_q) && ctrl_q[obd_pkg::CTRL_UNLOCK]
    && opt_index(addr_q) != obd_pkg::IDX_RSVD;
  assign mem_bus.wr_en = opt_write;
  assign mem_bus.wr_idx = opt_index(addr_q);
  assign mem_bus.wr_data = HWDATA[7:0];
  assign mem_bus.rd_idx[1] = opt_index(HADDR[7:0]);

  // Watchdog start bits are set-only: software cannot stop a started dog
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      ctrl_q <= obd_pkg::CTRL_RESET;
    end
    else if (wr_pend_q && addr_q == obd_pkg::OFS_CTRL)
    begin
      ctrl_q[obd_pkg::CTRL_TRIM_LO +: 4] <= HWDATA[obd_pkg::CTRL_TRIM_LO +: 4];
      ctrl_q[obd_pkg::CTRL_SLOW_SEL] <= HWDATA[obd_pkg::CTRL_SLOW_SEL];
      ctrl_q[obd_pkg::CTRL_UNLOCK] <= HWDATA[obd_pkg::CTRL_UNLOCK];
      ctrl_q[obd_pkg::CTRL_INDEP_START] <= ctrl_q[obd_pkg::CTRL_INDEP_START]
        | HWDATA[obd_pkg::CTRL_INDEP_START];
      ctrl_q[obd_pkg::CTRL_WINDOW_START] <= ctrl_q[obd_pkg::CTRL_WINDOW_START]
        | HWDATA[obd_pkg::CTRL_WINDOW_START];
    end
  end

  // ********************************************************************
  // Loader
  // ********************************************************************
  obd_pkg::obd_ld_t ld_state_q;
  logic [3:0] ld_idx_q;
  logic [7:0] raw_q [obd_pkg::OPT_COUNT];

  assign mem_bus.rd_idx[0] = ld_idx_q;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      ld_state_q <= obd_pkg::OBD_LD_FETCH;
      ld_idx_q <= 4'h0;
    end
    else
    begin
      unique case (ld_state_q)
        obd_pkg::OBD_LD_FETCH:
        begin
          ld_state_q <= obd_pkg::OBD_LD_CAPTURE;
        end
        obd_pkg::OBD_LD_CAPTURE:
        begin
          if (ld_idx_q == obd_pkg::IDX_KEY3)
          begin
            ld_state_q <= obd_pkg::OBD_LD_APPLY;
          end
          else
          begin
            ld_idx_q <= ld_idx_q + 4'h1;
            ld_state_q <= obd_pkg::OBD_LD_FETCH;
          end
        end
        obd_pkg::OBD_LD_APPLY:
        begin
          ld_state_q <= obd_pkg::OBD_LD_DONE;
        end
        obd_pkg::OBD_LD_DONE:
        begin
          ld_state_q <= obd_pkg::OBD_LD_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      for (int i = 0; i < obd_pkg::OPT_COUNT; i++)
      begin
        raw_q[i] <= 8'h00;
      end
    end
    else if (ld_state_q == obd_pkg::OBD_LD_CAPTURE && ld_idx_q != obd_pkg::IDX_RSVD)
    begin
      raw_q[ld_idx_q] <= mem_bus.rd_data[0];
    end
  end

  // ********************************************************************
  // Latched configuration
  // ********************************************************************
  logic apply;
  logic [7:0] cw;
  logic [7:0] ew;

  assign apply = ld_state_q == obd_pkg::OBD_LD_APPLY;
  assign cw = raw_q[obd_pkg::IDX_CLK_WDG];
  assign ew = raw_q[obd_pkg::IDX_EXT_WAKE];

  // Written only on the single apply cycle after reset
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      OPTIONS_LOADED <= 1'b0;
      FAST_OSC_TRIM_WIDTH <= 1'b0;
      SLOW_OSC_CPU_ALLOW <= 1'b0;
      INDEP_DOG_AUTO_START <= 1'b0;
      WINDOW_DOG_AUTO_START <= 1'b0;
      WINDOW_DOG_HALT_RESET <= 1'b0;
      EXT_CLOCK_SELECT <= 1'b0;
      WAKEUP_CLOCK_SOURCE <= 1'b0;
      WAKEUP_CLOCK_DIVIDER <= obd_pkg::OBD_DIV_RSVD;
      WAKEUP_DIVIDER_VALID <= 1'b0;
      CRYSTAL_SETTLE_HALF <= obd_pkg::SETTLE_HALF_4096;
      TEMP_UNPROTECT_EN <= 1'b0;
      TEMP_UNPROTECT_KEY <= 32'h0000_0000;
      TEMP_KEY_VALID <= 1'b0;
    end
    else if (apply)
    begin
      OPTIONS_LOADED <= 1'b1;
      FAST_OSC_TRIM_WIDTH <= cw[obd_pkg::BIT_TRIM_WIDE];
      SLOW_OSC_CPU_ALLOW <= cw[obd_pkg::BIT_SLOW_ALLOW];
      INDEP_DOG_AUTO_START <= cw[obd_pkg::BIT_INDEP_HW];
      WINDOW_DOG_AUTO_START <= cw[obd_pkg::BIT_WINDOW_HW];
      WINDOW_DOG_HALT_RESET <= cw[obd_pkg::BIT_HALT_RST];
      EXT_CLOCK_SELECT <= ew[obd_pkg::BIT_EXT_CLK];
      WAKEUP_CLOCK_SOURCE <= ew[obd_pkg::BIT_WAKE_SRC];
      WAKEUP_CLOCK_DIVIDER <= ew[obd_pkg::BIT_DIV_LO +: 2];
      WAKEUP_DIVIDER_VALID <= ew[obd_pkg::BIT_DIV_LO +: 2] != obd_pkg::OBD_DIV_RSVD;
      CRYSTAL_SETTLE_HALF <= settle_count(raw_q[obd_pkg::IDX_SETTLE]);
      TEMP_UNPROTECT_EN <= raw_q[obd_pkg::IDX_UNPROT][3:0] != obd_pkg::UNPROT_OFF_CODE;
      TEMP_UNPROTECT_KEY <= {raw_q[obd_pkg::IDX_KEY3], raw_q[obd_pkg::IDX_KEY0 + 4'h2],
        raw_q[obd_pkg::IDX_KEY0 + 4'h1], raw_q[obd_pkg::IDX_KEY0]};
      // Keys outside the allowed range are flagged, not repaired
      TEMP_KEY_VALID <= key_ok(raw_q[obd_pkg::IDX_KEY0])
        && key_ok(raw_q[obd_pkg::IDX_KEY0 + 4'h1])
        && key_ok(raw_q[obd_pkg::IDX_KEY0 + 4'h2])
        && key_ok(raw_q[obd_pkg::IDX_KEY3]);
    end
  end

  // ********************************************************************
  // Run-time controls gated by the latched options
  // ********************************************************************
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      FAST_OSC_TRIM <= 4'h0;
      SLOW_OSC_CPU_SEL <= 1'b0;
      INDEP_DOG_RUN <= 1'b0;
      WINDOW_DOG_RUN <= 1'b0;
    end
    else
    begin
      // Narrow trim drops the top bit so old 3-bit software stays valid
      FAST_OSC_TRIM <= FAST_OSC_TRIM_WIDTH ? ctrl_q[obd_pkg::CTRL_TRIM_LO +: 4]
        : {1'b0, ctrl_q[obd_pkg::CTRL_TRIM_LO +: 3]};
      SLOW_OSC_CPU_SEL <= SLOW_OSC_CPU_ALLOW && ctrl_q[obd_pkg::CTRL_SLOW_SEL];
      INDEP_DOG_RUN <= INDEP_DOG_RUN || INDEP_DOG_AUTO_START
        || ctrl_q[obd_pkg::CTRL_INDEP_START];
      WINDOW_DOG_RUN <= WINDOW_DOG_RUN || WINDOW_DOG_AUTO_START
        || ctrl_q[obd_pkg::CTRL_WINDOW_START];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      HALT_RESET_REQ <= 1'b0;
    end
    else
    begin
      HALT_RESET_REQ <= HALT_ENTRY && WINDOW_DOG_ACTIVE && WINDOW_DOG_HALT_RESET;
    end
  end

  // ********************************************************************
  // Status
  // ********************************************************************
  always_comb
  begin
    status = 8'h00;
    status[obd_pkg::STAT_LOADED] = OPTIONS_LOADED;
    status[obd_pkg::STAT_KEY_VALID] = TEMP_KEY_VALID;
    status[obd_pkg::STAT_UNPROT_EN] = TEMP_UNPROTECT_EN;
    status[obd_pkg::STAT_DIV_VALID] = WAKEUP_DIVIDER_VALID;
    status[obd_pkg::STAT_TRIM_WIDE] = FAST_OSC_TRIM_WIDTH;
  end

endmodule : obd_top

`default_nettype wire

// ---- tb/obd_top_assertions.sv ----
/*
  Port checker for the option byte decoder top module.
  Assumes it is bound to obd_top; it arms at the second reset, after the
  bench has first programmed the option storage.
*/
`default_nettype none

module obd_top_assertions (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HALT_ENTRY,
  input wire logic WINDOW_DOG_ACTIVE,
  input wire logic OPTIONS_LOADED,
  input wire logic FAST_OSC_TRIM_WIDTH,
  input wire logic [3:0] FAST_OSC_TRIM,
  input wire logic SLOW_OSC_CPU_ALLOW,
  input wire logic SLOW_OSC_CPU_SEL,
  input wire logic INDEP_DOG_AUTO_START,
  input wire logic INDEP_DOG_RUN,
  input wire logic WINDOW_DOG_AUTO_START,
  input wire logic WINDOW_DOG_RUN,
  input wire logic WINDOW_DOG_HALT_RESET,
  input wire logic HALT_RESET_REQ,
  input wire logic EXT_CLOCK_SELECT,
  input wire logic WAKEUP_CLOCK_SOURCE,
  input wire logic [1:0] WAKEUP_CLOCK_DIVIDER,
  input wire logic WAKEUP_DIVIDER_VALID,
  input wire logic [12:0] CRYSTAL_SETTLE_HALF,
  input wire logic TEMP_UNPROTECT_EN,
  input wire logic [31:0] TEMP_UNPROTECT_KEY,
  input wire logic TEMP_KEY_VALID
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******************************************************************
  // Properties
  // ******************************************************************
  // Storage is unknown until the first programmed load, so stay quiet
  logic seen_q = 1'b0;
  logic armed_q = 1'b0;
  always_ff @(posedge CLK)
  begin
    seen_q <= seen_q | RST_N;
    if (!RST_N && seen_q)
      armed_q <= 1'b1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N || !armed_q);
  a_trim_mask: assert property (!FAST_OSC_TRIM_WIDTH |-> !FAST_OSC_TRIM[3])
    else $error("trim bit 3 driven in narrow mode");
  a_slow_gate: assert property (SLOW_OSC_CPU_SEL |-> SLOW_OSC_CPU_ALLOW)
    else $error("slow clock selected while not allowed");
  a_indep_auto: assert property (INDEP_DOG_AUTO_START |-> ##[0:1] INDEP_DOG_RUN)
    else $error("independent watchdog not started");
  a_indep_sticky: assert property (INDEP_DOG_RUN |=> INDEP_DOG_RUN)
    else $error("independent watchdog stopped");
  a_window_auto: assert property (WINDOW_DOG_AUTO_START |-> ##[0:1] WINDOW_DOG_RUN)
    else $error("window watchdog not started");
  a_halt_req: assert property (HALT_ENTRY && WINDOW_DOG_ACTIVE && WINDOW_DOG_HALT_RESET
    |=> HALT_RESET_REQ)
    else $error("halt reset missing");
  a_halt_cause: assert property (HALT_RESET_REQ |-> $past(HALT_ENTRY) &&
    $past(WINDOW_DOG_ACTIVE) && $past(WINDOW_DOG_HALT_RESET))
    else $error("halt reset without cause");
  a_div_valid: assert property (WAKEUP_DIVIDER_VALID |-> WAKEUP_CLOCK_DIVIDER != 2'h0)
    else $error("reserved divider flagged valid");
  a_settle_set: assert property (OPTIONS_LOADED |->
    CRYSTAL_SETTLE_HALF inside {13'h0001, 13'h0010, 13'h0100, 13'h1000})
    else $error("settle count outside decoded set");
  a_load_time: assert property ($rose(RST_N) |-> !OPTIONS_LOADED ##[16:24] OPTIONS_LOADED)
    else $error("options not loaded in time");
  a_config_hold: assert property (OPTIONS_LOADED && $past(OPTIONS_LOADED) |->
    $stable({FAST_OSC_TRIM_WIDTH, SLOW_OSC_CPU_ALLOW, INDEP_DOG_AUTO_START,
    WINDOW_DOG_AUTO_START, WINDOW_DOG_HALT_RESET, EXT_CLOCK_SELECT, WAKEUP_CLOCK_SOURCE,
    WAKEUP_CLOCK_DIVIDER, CRYSTAL_SETTLE_HALF, TEMP_UNPROTECT_EN, TEMP_UNPROTECT_KEY,
    TEMP_KEY_VALID}))
    else $error("decoded setting changed after load");
  c_loaded: cover property ($rose(OPTIONS_LOADED));
  c_halt_req: cover property (HALT_RESET_REQ);
  c_slow_sel: cover property ($rose(SLOW_OSC_CPU_SEL));
endmodule : obd_top_assertions

bind obd_top obd_top_assertions u_chk (.CLK, .RST_N, .HALT_ENTRY, .WINDOW_DOG_ACTIVE,
  .OPTIONS_LOADED, .FAST_OSC_TRIM_WIDTH, .FAST_OSC_TRIM, .SLOW_OSC_CPU_ALLOW,
  .SLOW_OSC_CPU_SEL, .INDEP_DOG_AUTO_START, .INDEP_DOG_RUN, .WINDOW_DOG_AUTO_START,
  .WINDOW_DOG_RUN, .WINDOW_DOG_HALT_RESET, .HALT_RESET_REQ, .EXT_CLOCK_SELECT,
  .WAKEUP_CLOCK_SOURCE, .WAKEUP_CLOCK_DIVIDER, .WAKEUP_DIVIDER_VALID,
  .CRYSTAL_SETTLE_HALF, .TEMP_UNPROTECT_EN, .TEMP_UNPROTECT_KEY, .TEMP_KEY_VALID);

`default_nettype wire

// ---- tb/obd_top_tb_top.sv ----
/*
  Self-checking bench: programs option bytes over AHB-Lite, resets, and
  checks the decoded outputs, control bits and halt reset.
  Assumes obd_top is the only slave, so HREADYOUT feeds HREADY.
*/
`default_nettype none

module obd_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ******************************************************************
  // Signals and design
  // ******************************************************************
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0;
  logic HALT_ENTRY = 1'b0;
  logic WINDOW_DOG_ACTIVE = 1'b0;
  logic HREADYOUT, HRESP, OPTIONS_LOADED, FAST_OSC_TRIM_WIDTH, SLOW_OSC_CPU_ALLOW;
  logic SLOW_OSC_CPU_SEL, INDEP_DOG_AUTO_START, INDEP_DOG_RUN, WINDOW_DOG_AUTO_START;
  logic WINDOW_DOG_RUN, WINDOW_DOG_HALT_RESET, HALT_RESET_REQ, EXT_CLOCK_SELECT;
  logic WAKEUP_CLOCK_SOURCE, WAKEUP_DIVIDER_VALID, TEMP_UNPROTECT_EN, TEMP_KEY_VALID;
  logic [31:0] HRDATA, TEMP_UNPROTECT_KEY;
  logic [3:0] FAST_OSC_TRIM;
  logic [1:0] WAKEUP_CLOCK_DIVIDER;
  logic [12:0] CRYSTAL_SETTLE_HALF;
  int n_errors = 0;
  int n_tests = 0;
  // Option sets chosen to reach every divider and settle code
  logic [7:0] opt_a [4] = '{8'h1F, 8'h00, 8'h15, 8'h0A};
  logic [7:0] opt_b [4] = '{8'h0D, 8'h02, 8'h07, 8'h08};
  logic [7:0] opt_s [4] = '{8'hD2, 8'hB4, 8'hE1, 8'h00};
  logic [7:0] opt_u [4] = '{8'h05, 8'h0A, 8'h35, 8'h06};
  logic [7:0] opt_k [4] = '{8'h11, 8'hFE, 8'h01, 8'h5A};

  always #2 CLK = ~CLK;

  obd_top u_dut (.CLK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY(HREADYOUT), .HREADYOUT, .HRDATA, .HRESP, .HALT_ENTRY, .WINDOW_DOG_ACTIVE,
    .OPTIONS_LOADED, .FAST_OSC_TRIM_WIDTH, .FAST_OSC_TRIM, .SLOW_OSC_CPU_ALLOW,
    .SLOW_OSC_CPU_SEL, .INDEP_DOG_AUTO_START, .INDEP_DOG_RUN, .WINDOW_DOG_AUTO_START,
    .WINDOW_DOG_RUN, .WINDOW_DOG_HALT_RESET, .HALT_RESET_REQ, .EXT_CLOCK_SELECT,
    .WAKEUP_CLOCK_SOURCE, .WAKEUP_CLOCK_DIVIDER, .WAKEUP_DIVIDER_VALID,
    .CRYSTAL_SETTLE_HALF, .TEMP_UNPROTECT_EN, .TEMP_UNPROTECT_KEY, .TEMP_KEY_VALID);

  // ******************************************************************
  // Tasks
  // ******************************************************************
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : cmp

  // Ready is read at the falling edge, which equals what the next rising edge samples
  task automatic wait_rdy(output logic [31:0] q);
    logic r;
    r = 1'b0;
    for (int n = 0; n < 50 && r !== 1'b1; n++)
    begin
      @(negedge CLK);
      r = HREADYOUT;
      q = HRDATA;
      @(posedge CLK);
    end
    if (r !== 1'b1)
      cmp(32'h0, 32'h1, "bus wait");
  endtask : wait_rdy

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    HSEL <= 1'b1;
    HTRANS <= obd_pkg::HTRANS_NONSEQ;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    wait_rdy(q);
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy(q);
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    ahb(1'b1, a, {24'h0, d}, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string what);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    cmp(q, {24'h0, e}, what);
  endtask : rdc

  task automatic t_program(input int i);
    wr(obd_pkg::OFS_CTRL, 8'h80);
    wr(obd_pkg::OFS_CLK_WDG, opt_a[i]);
    wr(8'h04, opt_b[i]);
    wr(8'h08, opt_s[i]);
    wr(8'h0C, opt_u[i]);
    wr(8'h10, 8'hAA);
    wr(8'h14, opt_k[i]);
    for (int k = 0; k < 3; k++)
      wr(8'h18 + 8'(4 * k), 8'h22 + 8'(17 * k));
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    for (int n = 0; n < 40 && OPTIONS_LOADED !== 1'b1; n++)
      @(negedge CLK);
    cmp(32'(OPTIONS_LOADED), 32'h1, "loaded");
    @(posedge CLK);
  endtask : t_program

  task automatic t_decode(input int i);
    logic [7:0] a, b, u, k;
    logic [12:0] hs;
    logic kv, en;
    a = opt_a[i];
    b = opt_b[i];
    u = opt_u[i];
    k = opt_k[i];
    kv = k != 8'h00 && k != 8'hFF;
    en = u[3:0] != 4'h5;
    case (opt_s[i])
      8'hE1: hs = 13'h0001;
      8'hD2: hs = 13'h0010;
      8'hB4: hs = 13'h0100;
      default: hs = 13'h1000;
    endcase
    cmp(32'(FAST_OSC_TRIM_WIDTH), 32'(a[0]), "trim width");
    cmp(32'(SLOW_OSC_CPU_ALLOW), 32'(a[1]), "slow allow");
    cmp(32'(INDEP_DOG_AUTO_START), 32'(a[2]), "indep auto");
    cmp(32'(WINDOW_DOG_AUTO_START), 32'(a[3]), "window auto");
    cmp(32'(WINDOW_DOG_HALT_RESET), 32'(a[4]), "halt option");
    cmp(32'(EXT_CLOCK_SELECT), 32'(b[3]), "ext clock");
    cmp(32'(WAKEUP_CLOCK_SOURCE), 32'(b[2]), "wake source");
    cmp(32'({WAKEUP_DIVIDER_VALID, WAKEUP_CLOCK_DIVIDER}), 32'({b[1:0] != 2'h0, b[1:0]}),
      "divider");
    cmp(32'(CRYSTAL_SETTLE_HALF), 32'(hs), "settle");
    cmp(32'(TEMP_UNPROTECT_EN), 32'(en), "unprotect");
    cmp(TEMP_UNPROTECT_KEY, {8'h44, 8'h33, 8'h22, k}, "key");
    cmp(32'(TEMP_KEY_VALID), 32'(kv), "key valid");
    rdc(obd_pkg::OFS_CTRL, 8'h00, "ctrl reset");
    rdc(8'h10, 8'h00, "reserved");
    rdc(8'h08, opt_s[i], "settle byte");
    rdc(obd_pkg::OFS_STATUS, {3'h0, a[0], b[1:0] != 2'h0, en, kv, 1'b1}, "status");
    cmp(32'(HRESP), 32'(obd_pkg::HRESP_OKAY), "response");
    wr(obd_pkg::OFS_CLK_WDG, ~a);
    rdc(obd_pkg::OFS_CLK_WDG, a, "locked write");
    rdc(8'h30, 8'h00, "unmapped");
  endtask : t_decode

  task automatic t_control(input int i);
    logic [7:0] a;
    a = opt_a[i];
    cmp(32'(INDEP_DOG_RUN), 32'(a[2]), "indep idle");
    cmp(32'(WINDOW_DOG_RUN), 32'(a[3]), "window idle");
    wr(obd_pkg::OFS_CTRL, 8'hFF);
    repeat (2) @(negedge CLK);
    cmp(32'(FAST_OSC_TRIM), a[0] ? 32'hF : 32'h7, "trim");
    cmp(32'(SLOW_OSC_CPU_SEL), 32'(a[1]), "slow select");
    cmp(32'({INDEP_DOG_RUN, WINDOW_DOG_RUN}), 32'h3, "dogs run");
    @(posedge CLK);
    wr(obd_pkg::OFS_CLK_WDG, ~a);
    rdc(obd_pkg::OFS_CLK_WDG, ~a, "unlocked write");
    cmp(32'(FAST_OSC_TRIM_WIDTH), 32'(a[0]), "held width");
  endtask : t_control

  task automatic t_halt(input int i);
    for (int j = 0; j < 2; j++)
    begin
      WINDOW_DOG_ACTIVE <= j == 0;
      HALT_ENTRY <= 1'b1;
      @(posedge CLK);
      HALT_ENTRY <= 1'b0;
      @(negedge CLK);
      cmp(32'(HALT_RESET_REQ), 32'(j == 0 && opt_a[i][4]), "halt reset");
      @(posedge CLK);
    end
    WINDOW_DOG_ACTIVE <= 1'b0;
  endtask : t_halt

  // ******************************************************************
  // Sequence
  // ******************************************************************
  initial
  begin
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    for (int i = 0; i < 4; i++)
    begin
      t_program(i);
      t_decode(i);
      t_control(i);
      t_halt(i);
      $display("option set %0d done", i);
    end
    conclude();
  end

  initial
  begin
    #20000;
    n_errors++;
    $display("unexpected at %0t: run did not finish", $time);
    conclude();
  end
endmodule : obd_top_tb_top

`default_nettype wire
